// >>> hw/roc_pkg.sv
package roc_pkg;

  // Serial link widths.
  localparam int unsigned   DATA_W       = 24;
  localparam int unsigned   LEN_W        = 5;
  localparam int unsigned   ADDR_W       = 7;
  localparam int unsigned   CNT_W        = 8;
  localparam int unsigned   CMD_W        = 8;

  // Command byte layout.
  localparam int unsigned   CMD_WR_BIT   = 7;
  localparam int unsigned   CMD_ADDR_LSB = 0;

  // Register map.
  localparam logic [6:0]    ONES_CNT_ADDR = 7'h7e;
  localparam logic [4:0]    ONES_CNT_LEN  = 5'h08;
  localparam logic [7:0]    ONES_CNT_RST  = 8'h00;
  localparam logic [4:0]    DEFAULT_LEN   = 5'h08;
  localparam logic [4:0]    CMD_LEN       = 5'h08;

  // Pin reset levels: chip select idle high, clock idle high, data low.
  localparam logic [2:0]    PIN_RST       = 3'b110;
  localparam int unsigned   PIN_CS        = 2;
  localparam int unsigned   PIN_SCLK      = 1;
  localparam int unsigned   PIN_DIN       = 0;

  typedef struct packed {
    logic cs_b;
    logic sclk;
    logic din;
  } roc_pins_s;

  typedef struct packed {
    logic              valid;
    logic [6:0]        addr;
    logic [23:0]       data;
  } roc_wr_s;

  typedef enum logic [1:0] {
    ST_CMD   = 2'b00,
    ST_LOAD  = 2'b01,
    ST_READ  = 2'b10,
    ST_WRITE = 2'b11
  } roc_state_e;

endpackage

// >>> hw/roc_serial_checksum.sv
`timescale 1ns/100ps
module roc_serial_checksum
  import roc_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,
  input  wire roc_pkg::roc_pins_s      pins_i,
  output logic                         dout_o,
  output logic                         dout_oe_o,
  output logic [roc_pkg::ADDR_W-1:0]   reg_addr_o,
  input  wire logic [roc_pkg::DATA_W-1:0] reg_rdata_i,
  input  wire logic [roc_pkg::LEN_W-1:0]  reg_len_i,
  output roc_pkg::roc_wr_s             wr_o,
  output logic [roc_pkg::CNT_W-1:0]    ones_count_o
);
  import roc_pkg::*;

  // The serial pins arrive from the host with no relation to the system
  // clock. Each pin passes three flip-flops; the filtered level only moves
  // once stages two and three agree, so a single metastable sample or a
  // short glitch on a slow clock edge cannot create a false edge.
  // The filtered copies reset to the idle levels of the pins, so that no
  // edge is seen in the first cycles after reset.

  // Three-stage synchronisers; a level counts once stages two and three agree.
  logic [2:0]       s1_r, s2_r, s3_r, flt_r;
  logic [2:0]       s1_nxt, s2_nxt, s3_nxt, flt_nxt;
  logic             flt_prev_sclk_r, flt_prev_cs_r;
  logic             sclk_rise, sclk_fall, cs_fall, cs_b;

  always_comb begin
    s1_nxt  = pins_i;
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r            <= PIN_RST;
      s2_r            <= PIN_RST;
      s3_r            <= PIN_RST;
      flt_r           <= PIN_RST;
      flt_prev_sclk_r <= 1'b1;
      flt_prev_cs_r   <= 1'b1;
    end else begin
      s1_r            <= s1_nxt;
      s2_r            <= s2_nxt;
      s3_r            <= s3_nxt;
      flt_r           <= flt_nxt;
      flt_prev_sclk_r <= flt_r[PIN_SCLK];
      flt_prev_cs_r   <= flt_r[PIN_CS];
    end
  end

  // Edges are found on the filtered levels in the first cycle that they hold a new value.
  // The host must keep each serial clock half period well above the
  // synchroniser latency, or edges are lost.

  assign cs_b      = flt_r[PIN_CS];
  assign sclk_rise = flt_r[PIN_SCLK] & ~flt_prev_sclk_r;
  assign sclk_fall = ~flt_r[PIN_SCLK] & flt_prev_sclk_r;
  assign cs_fall   = ~cs_b & flt_prev_cs_r;

  // Serial engine state.
  // The engine walks command, then either load and read, or write. The ones count is
  // only touched in the load and read states, so writes leave it alone and
  // an aborted read keeps the partial sum it had reached.
  roc_state_e           state_r, state_nxt;
  logic [CMD_W-1:0]     cmd_r, cmd_nxt;
  logic [LEN_W-1:0]     bits_r, bits_nxt;
  logic [LEN_W-1:0]     len_r, len_nxt;
  logic [ADDR_W-1:0]    addr_r, addr_nxt;
  logic [DATA_W-1:0]    shift_r, shift_nxt;
  logic [CNT_W-1:0]     count_r, count_nxt;
  logic                 dout_r, dout_nxt;
  roc_wr_s              wr_r, wr_nxt;
  logic [LEN_W-1:0]     len_eff;
  logic [DATA_W-1:0]    load_data;
  logic [LEN_W-1:0]     pad;
  logic [CMD_W-1:0]     cmd_full;

  // Length and data of the addressed register. The ones count register is
  // served from inside the block, so a read of it returns the value held
  // before the load cycle clears it, and is then counted like any other.
  // A length of zero from the register file is taken as the default.
  always_comb begin
    if (addr_r == ONES_CNT_ADDR) begin
      len_eff   = ONES_CNT_LEN;
      load_data = {{(DATA_W-CNT_W){1'b0}}, count_r};
    end else begin
      len_eff   = (reg_len_i == '0) ? DEFAULT_LEN : reg_len_i;
      load_data = reg_rdata_i;
    end
    pad = LEN_W'(DATA_W) - len_eff;
  end

  always_comb begin
    state_nxt    = state_r;
    cmd_nxt      = cmd_r;
    bits_nxt     = bits_r;
    len_nxt      = len_r;
    addr_nxt     = addr_r;
    shift_nxt    = shift_r;
    count_nxt    = count_r;
    dout_nxt     = dout_r;
    wr_nxt       = wr_r;
    wr_nxt.valid = 1'b0;
    cmd_full     = {cmd_r[CMD_W-2:0], flt_r[PIN_DIN]};
    if (cs_b || cs_fall) begin
      state_nxt = ST_CMD;
      bits_nxt  = '0;
      dout_nxt  = 1'b0;
    end else begin
      case (state_r)
        ST_CMD: begin
          if (sclk_fall) begin
            cmd_nxt  = cmd_full;
            bits_nxt = bits_r + 5'h01;
            if (bits_r + 5'h01 == CMD_LEN) begin
              bits_nxt  = '0;
              addr_nxt  = cmd_full[CMD_ADDR_LSB +: ADDR_W];
              state_nxt = cmd_full[CMD_WR_BIT] ? ST_WRITE : ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          // Data is aligned to the top of the shifter so the most
          // significant bit of the register leaves first, and the count
          // is cleared before that bit can reach the output pin.
          shift_nxt = load_data << pad;
          len_nxt   = len_eff;
          count_nxt = ONES_CNT_RST;
          state_nxt = ST_READ;
        end
        ST_READ: begin
          // Each rising serial clock edge presents one bit and adds it to
          // the count in the same cycle. Once all bits have left, the next
          // falling edge ends the transfer and the engine waits for a new
          // command byte.
          if (sclk_rise && bits_r != len_r) begin
            dout_nxt  = shift_r[DATA_W-1];
            shift_nxt = {shift_r[DATA_W-2:0], 1'b0};
            count_nxt = count_r + {7'h00, shift_r[DATA_W-1]};
            bits_nxt  = bits_r + 5'h01;
          end else if (sclk_fall && bits_r == len_r) begin
            bits_nxt  = '0;
            state_nxt = ST_CMD;
          end
        end
        ST_WRITE: begin
          // The ones count is left alone here.
          if (sclk_fall) begin
            wr_nxt.data = {wr_r.data[DATA_W-2:0], flt_r[PIN_DIN]};
            bits_nxt    = bits_r + 5'h01;
            if (bits_r + 5'h01 == len_eff) begin
              wr_nxt.valid = (addr_r != ONES_CNT_ADDR);
              wr_nxt.addr  = addr_r;
              bits_nxt     = '0;
              state_nxt    = ST_CMD;
            end
          end
        end
        default: begin
          state_nxt = ST_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_CMD;
      cmd_r   <= '0;
      bits_r  <= '0;
      len_r   <= DEFAULT_LEN;
      addr_r  <= '0;
      shift_r <= '0;
      count_r <= ONES_CNT_RST;
      dout_r  <= 1'b0;
      wr_r    <= '0;
    end else begin
      state_r <= state_nxt;
      cmd_r   <= cmd_nxt;
      bits_r  <= bits_nxt;
      len_r   <= len_nxt;
      addr_r  <= addr_nxt;
      shift_r <= shift_nxt;
      count_r <= count_nxt;
      dout_r  <= dout_nxt;
      wr_r    <= wr_nxt;
    end
  end

  // The output enable is dropped in the cycle the filtered chip select goes high, so a
  // deselected device stops driving the shared data line after the synchroniser latency.

  assign dout_o       = dout_r;
  assign dout_oe_o    = (state_r == ST_READ) && !cs_b;
  assign reg_addr_o   = addr_r;
  assign wr_o         = wr_r;
  assign ones_count_o = count_r;

endmodule

// >>> verif/roc_checker.sv
`timescale 1ns/100ps
module roc_chk
  import roc_pkg::*;
(
  input wire logic               clk_sys_i,
  input wire logic               rst_b_i,
  input wire roc_pkg::roc_pins_s pins_i,
  input wire logic               dout_o,
  input wire logic               dout_oe_o,
  input wire logic [6:0]         reg_addr_o,
  input wire logic [23:0]        reg_rdata_i,
  input wire logic [4:0]         reg_len_i,
  input wire roc_pkg::roc_wr_s   wr_o,
  input wire logic [7:0]         ones_count_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  count_step_a: assert property ($changed(ones_count_o) |->
    ones_count_o == 8'h00 || ones_count_o == $past(ones_count_o) + 8'h01)
    else $error("count jumped");
  count_bit_a: assert property ($changed(ones_count_o) &&
    ones_count_o != 8'h00 |-> dout_o && dout_oe_o) else $error("bad step");
  clear_early_a: assert property ($rose(dout_oe_o) |->
    ##[0:2] ones_count_o == 8'h00) else $error("count not cleared");
  write_ro_a: assert property (wr_o.valid |->
    wr_o.addr != ONES_CNT_ADDR) else $error("count written");
  write_keep_a: assert property (wr_o.valid |->
    $stable(ones_count_o) && !dout_oe_o) else $error("count moved");
  write_pulse_a: assert property (wr_o.valid |=>
    !wr_o.valid) else $error("long write pulse");
  cs_idle_a: assert property (pins_i.cs_b [*5] |->
    !dout_oe_o) else $error("driving while deselected");
  addr_hold_a: assert property (dout_oe_o && $past(dout_oe_o) |->
    $stable(reg_addr_o)) else $error("address moved in read");
  cover property ($rose(dout_oe_o));
  cover property (wr_o.valid);
  cover property (ones_count_o == 8'h18);
endmodule

// >>> verif/roc_host.sv
`timescale 1ns/100ps
module roc_host (
  output roc_pkg::roc_pins_s pins_o,
  input  wire logic          dout_i
);
  initial pins_o = roc_pkg::PIN_RST;
  // Sends n falls: command first, then len data bits; n short aborts.
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                      input int n, input int len, output logic [23:0] rd);
    rd = 24'h0;
    pins_o.cs_b = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      pins_o.din = (i < 8) ? cmd[7-i] : wd[len+7-i];
      #20 pins_o.sclk = 1'b0;
      if (i >= 8) rd = {rd[22:0], dout_i};
      #40 pins_o.sclk = 1'b1;
      #20;
    end
    pins_o.din = ~pins_o.din;
    #20 pins_o.cs_b = 1'b1;
    #80;
  endtask
endmodule

// >>> verif/roc_serial_checksum_tb.sv
`timescale 1ns/100ps
module roc_serial_checksum_tb;
  import roc_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  roc_pins_s   pins;
  logic        dout_o;
  logic        dout_oe_o;
  logic [6:0]  reg_addr_o;
  logic [23:0] regv = 24'h0;
  logic [23:0] rd;
  logic [4:0]  lenv = 5'h08;
  roc_wr_s     wr_o;
  roc_wr_s     wr_seen;
  logic [7:0]  ones_count_o;
  int          miscompares = 0;
  int          n_compared = 0;
  int          nwr = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (wr_o.valid) begin
    wr_seen <= wr_o;
    nwr <= nwr + 1;
  end
  roc_serial_checksum roc_serial_checksum_i (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .pins_i(pins), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .reg_addr_o(reg_addr_o),
    .reg_rdata_i(reg_addr_o == ONES_CNT_ADDR ? {16'h0, ones_count_o} : regv),
    .reg_len_i(reg_addr_o == ONES_CNT_ADDR ? ONES_CNT_LEN : lenv),
    .wr_o(wr_o), .ones_count_o(ones_count_o));
  roc_host roc_host_i (.pins_o(pins), .dout_i(dout_o));
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic t_read(logic [23:0] v, logic [4:0] len, logic [6:0] a);
    logic [23:0] k;
    k = 24'($countones(v));
    regv = v;
    lenv = len;
    roc_host_i.xfer({1'b0, a}, 24'h0, 8 + len, len, rd);
    chk("read data", v, rd);
    chk("count", k, {16'h0, ones_count_o});
    roc_host_i.xfer({1'b0, ONES_CNT_ADDR}, 24'h0, 16, 8, rd);
    chk("count read", k, rd);
    chk("self count", 24'($countones(k)), {16'h0, ones_count_o});
    chk("count addr", {17'h0, ONES_CNT_ADDR}, {17'h0, reg_addr_o});
    chk("oe idle", 24'h0, {23'h0, dout_oe_o});
    $display("read test done");
  endtask
  task automatic t_write(logic [6:0] a, logic [23:0] v, logic [7:0] k);
    int n0;
    n0 = nwr;
    lenv = 5'h18;
    roc_host_i.xfer({1'b1, a}, v, a == ONES_CNT_ADDR ? 16 : 32,
                    a == ONES_CNT_ADDR ? 8 : 24, rd);
    chk("writes", 24'(n0 + (a != ONES_CNT_ADDR)), 24'(nwr));
    if (a != ONES_CNT_ADDR) chk("wr data", v, wr_seen.data);
    if (a != ONES_CNT_ADDR) chk("wr addr", {17'h0, a}, {17'h0, wr_seen.addr});
    chk("count kept", {16'h0, k}, {16'h0, ones_count_o});
    $display("write test done");
  endtask
  task automatic t_abort;
    regv = 24'h000001;
    lenv = 5'h18;
    roc_host_i.xfer(8'h01, 24'h0, 13, 24, rd);
    chk("abort count", 24'h0, {16'h0, ones_count_o});
    chk("abort oe", 24'h0, {23'h0, dout_oe_o});
    $display("abort test done");
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    chk("reset count", 24'h0, {16'h0, ones_count_o});
    chk("reset oe", 24'h0, {23'h0, dout_oe_o});
    t_read(24'hffffff, 5'h18, 7'h01);
    t_read(24'h000000, 5'h08, 7'h02);
    t_read(24'h000001, 5'h01, 7'h03);
    t_write(7'h05, 24'ha5a5a5, 8'h01);
    t_write(ONES_CNT_ADDR, 24'h0000ff, 8'h01);
    t_abort();
    t_read(24'h80000f, 5'h18, 7'h04);
    close_out();
  end
endmodule
bind roc_serial_checksum roc_chk roc_chk_i (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .pins_i(pins_i), .dout_o(dout_o),
  .dout_oe_o(dout_oe_o), .reg_addr_o(reg_addr_o),
  .reg_rdata_i(reg_rdata_i), .reg_len_i(reg_len_i), .wr_o(wr_o),
  .ones_count_o(ones_count_o));
